/* common/udh_pkg.sv */
`default_nettype none
package udh_pkg;

    // Register port shape
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] FIFO_CTRL_OFS = 3'h2;
    localparam logic [ADDR_W-1:0] MODEM_CTRL_OFS = 3'h4;
    localparam logic [ADDR_W-1:0] PIN_STATUS_OFS = 3'h5;
    localparam logic [ADDR_W-1:0] RX_LEVEL_OFS = 3'h6;
    localparam logic [ADDR_W-1:0] TX_LEVEL_OFS = 3'h7;

    // Modem control fields
    localparam int unsigned MC_DTR_BIT = 0;
    localparam int unsigned MC_RTS_BIT = 1;
    localparam int unsigned MC_OUT1_BIT = 2;
    localparam int unsigned MC_OUT2_BIT = 3;
    localparam int unsigned MC_LOOP_BIT = 4;
    localparam int unsigned MC_W = 5;

    // FIFO control fields
    localparam int unsigned FC_FIFO_EN_BIT = 0;
    localparam int unsigned FC_RX_CLR_BIT = 1;
    localparam int unsigned FC_TX_CLR_BIT = 2;
    localparam int unsigned FC_DMA_MODE_BIT = 3;

    // Pin status fields
    localparam int unsigned PS_RX_RDY_BIT = 0;
    localparam int unsigned PS_TX_RDY_BIT = 1;
    localparam int unsigned PS_FIFO_EN_BIT = 2;
    localparam int unsigned PS_DMA_MODE_BIT = 3;
    localparam int unsigned PS_SIN_BIT = 4;
    localparam int unsigned PS_SERIAL_OUT_BIT = 5;

    // Reset values
    localparam logic [MC_W-1:0] MODEM_CTRL_RST = 5'h00;
    localparam logic FIFO_EN_RST = 1'b0;
    localparam logic DMA_MODE_RST = 1'b0;
    localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;

    // FIFO geometry
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned LVL_W = 5;

    typedef struct packed {
        logic [LVL_W-1:0] rx_level;
        logic [LVL_W-1:0] tx_level;
        logic rx_trigger;
        logic rx_timeout;
    } udh_fifo_stat_t;

    typedef struct packed {
        logic cs;
        logic wr;
        logic wr_n;
        logic rd;
        logic rd_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } udh_cpu_req_t;

    typedef enum logic {
        RDY_RELEASED,
        RDY_ASSERTED
    } udh_rdy_state_t;

endpackage
`default_nettype wire

/* src/udh_sync2.sv */
`default_nettype none
module udh_sync2 #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '1
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cen,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end
        else if (cen)
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule
`default_nettype wire

/* src/udh_uart_dma_pins.sv */
// Behaviour
// - RTS pin is driven low while the modem control RTS bit is set and high while it is clear.
// - Reset puts the RTS pin at its inactive high level.
// - In loopback the RTS pin stays inactive whatever the modem control bit holds.
// - With FIFOs on the dma mode bit picks the signalling type of both ready pins; without FIFOs only single-transfer applies.
// - Single-transfer moves one transfer per request; multi-transfer keeps requesting until receive FIFO empties or transmit FIFO fills.
// - Single-transfer receive ready is low while any received character is held and high when none remain.
// - Multi-transfer receive ready goes low at trigger level or timeout and high once the receive FIFO is empty.
// - Single-transfer transmit ready is low while transmit FIFO and holding register are empty and high after a character is loaded.
// - Multi-transfer transmit ready goes low when the transmit FIFO is empty and high only when it is completely full.
// - Reset puts the serial output at the marking high level.
// - A write goes to the addressed register while chip select is high and either write strobe is active.
// - A read comes from the addressed register while chip select is high and either read strobe is active.
`default_nettype none
module udh_uart_dma_pins #(
    parameter int unsigned FIFO_DEPTH = udh_pkg::FIFO_DEPTH
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cen,
    input wire udh_pkg::udh_cpu_req_t cpu_req,
    output logic [udh_pkg::DATA_W-1:0] cpu_rdata,
    input wire udh_pkg::udh_fifo_stat_t fifo_stat,
    input wire logic tx_serial_bit,
    input wire logic serial_in,
    output logic rx_serial_bit,
    output logic serial_out,
    output logic rts_n,
    output logic dtr_n,
    output logic out1_n,
    output logic out2_n,
    output logic loopback,
    output logic fifo_enabled,
    output logic rx_fifo_clear,
    output logic tx_fifo_clear,
    output logic rx_dma_ready_n,
    output logic tx_dma_ready_n
);

    localparam logic [udh_pkg::LVL_W-1:0] FULL_LEVEL = FIFO_DEPTH[udh_pkg::LVL_W-1:0];

    // Either polarity of a strobe counts; the idle one is tied off outside
    function automatic logic strobe_active(input logic hi, input logic lo_n);
        strobe_active = hi | ~lo_n;
    endfunction

    function automatic logic level_empty(input logic [udh_pkg::LVL_W-1:0] lvl);
        level_empty = (lvl == '0);
    endfunction

    logic wr_en;
    logic rd_en;
    logic sin_sync;
    logic dma_mode_eff;

    logic [udh_pkg::MC_W-1:0] modem_ctrl_q;
    logic fifo_en_q;
    logic dma_mode_q;
    logic [udh_pkg::DATA_W-1:0] rdata_q;
    logic rdata_d;
    logic rx_clr_q;
    logic tx_clr_q;
    logic rts_n_q;
    logic dtr_n_q;
    logic out1_n_q;
    logic out2_n_q;
    logic loop_q;
    logic serial_out_q;
    logic rx_line_q;
    logic rx_rdy_n_q;
    logic tx_rdy_n_q;
    udh_pkg::udh_rdy_state_t rx_state_q;
    udh_pkg::udh_rdy_state_t rx_state_d;
    udh_pkg::udh_rdy_state_t tx_state_q;
    udh_pkg::udh_rdy_state_t tx_state_d;

    // Register access decode
    assign wr_en = cpu_req.cs & strobe_active(cpu_req.wr, cpu_req.wr_n);
    assign rd_en = cpu_req.cs & strobe_active(cpu_req.rd, cpu_req.rd_n);

    udh_sync2 #(
        .WIDTH(1),
        .RST_VAL(1'b1)
    ) u_sin_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .cen(cen),
        .async_in(serial_in),
        .sync_out(sin_sync)
    );

    // Modem control register
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            modem_ctrl_q <= udh_pkg::MODEM_CTRL_RST;
        end
        else if (cen && wr_en && cpu_req.addr == udh_pkg::MODEM_CTRL_OFS)
        begin
            modem_ctrl_q <= cpu_req.wdata[udh_pkg::MC_W-1:0];
        end
    end

    // FIFO control register; mode bits only stick while FIFOs are being enabled
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fifo_en_q <= udh_pkg::FIFO_EN_RST;
            dma_mode_q <= udh_pkg::DMA_MODE_RST;
        end
        else if (cen && wr_en && cpu_req.addr == udh_pkg::FIFO_CTRL_OFS)
        begin
            fifo_en_q <= cpu_req.wdata[udh_pkg::FC_FIFO_EN_BIT];
            if (cpu_req.wdata[udh_pkg::FC_FIFO_EN_BIT])
            begin
                dma_mode_q <= cpu_req.wdata[udh_pkg::FC_DMA_MODE_BIT];
            end
            else
            begin
                dma_mode_q <= 1'b0;
            end
        end
    end

    // FIFO clear pulses: explicit clear bits, or any change of FIFO enable
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_clr_q <= 1'b0;
            tx_clr_q <= 1'b0;
        end
        else if (cen)
        begin
            if (wr_en && cpu_req.addr == udh_pkg::FIFO_CTRL_OFS)
            begin
                rx_clr_q <= cpu_req.wdata[udh_pkg::FC_RX_CLR_BIT]
                    | (cpu_req.wdata[udh_pkg::FC_FIFO_EN_BIT] != fifo_en_q);
                tx_clr_q <= cpu_req.wdata[udh_pkg::FC_TX_CLR_BIT]
                    | (cpu_req.wdata[udh_pkg::FC_FIFO_EN_BIT] != fifo_en_q);
            end
            else
            begin
                rx_clr_q <= 1'b0;
                tx_clr_q <= 1'b0;
            end
        end
    end

    // Modem control pins, all active low, held inactive in loopback
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rts_n_q <= 1'b1;
            dtr_n_q <= 1'b1;
            out1_n_q <= 1'b1;
            out2_n_q <= 1'b1;
            loop_q <= 1'b0;
        end
        else if (cen)
        begin
            loop_q <= modem_ctrl_q[udh_pkg::MC_LOOP_BIT];
            if (modem_ctrl_q[udh_pkg::MC_LOOP_BIT])
            begin
                rts_n_q <= 1'b1;
                dtr_n_q <= 1'b1;
                out1_n_q <= 1'b1;
                out2_n_q <= 1'b1;
            end
            else
            begin
                rts_n_q <= ~modem_ctrl_q[udh_pkg::MC_RTS_BIT];
                dtr_n_q <= ~modem_ctrl_q[udh_pkg::MC_DTR_BIT];
                out1_n_q <= ~modem_ctrl_q[udh_pkg::MC_OUT1_BIT];
                out2_n_q <= ~modem_ctrl_q[udh_pkg::MC_OUT2_BIT];
            end
        end
    end

    // Serial path; loopback keeps the line marking and feeds the receiver internally
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            serial_out_q <= 1'b1;
            rx_line_q <= 1'b1;
        end
        else if (cen)
        begin
            if (modem_ctrl_q[udh_pkg::MC_LOOP_BIT])
            begin
                serial_out_q <= 1'b1;
                rx_line_q <= tx_serial_bit;
            end
            else
            begin
                serial_out_q <= tx_serial_bit;
                rx_line_q <= sin_sync;
            end
        end
    end

    // Multi-transfer only exists with FIFOs on
    assign dma_mode_eff = fifo_en_q & dma_mode_q;

    // Receive ready hysteresis for multi-transfer
    always_comb
    begin
        rx_state_d = rx_state_q;
        unique case (rx_state_q)
            udh_pkg::RDY_RELEASED:
            begin
                if (fifo_stat.rx_trigger || fifo_stat.rx_timeout)
                begin
                    rx_state_d = udh_pkg::RDY_ASSERTED;
                end
            end
            udh_pkg::RDY_ASSERTED:
            begin
                if (level_empty(fifo_stat.rx_level))
                begin
                    rx_state_d = udh_pkg::RDY_RELEASED;
                end
            end
        endcase
    end

    // Transmit ready hysteresis for multi-transfer
    always_comb
    begin
        tx_state_d = tx_state_q;
        unique case (tx_state_q)
            udh_pkg::RDY_RELEASED:
            begin
                if (level_empty(fifo_stat.tx_level))
                begin
                    tx_state_d = udh_pkg::RDY_ASSERTED;
                end
            end
            udh_pkg::RDY_ASSERTED:
            begin
                if (fifo_stat.tx_level >= FULL_LEVEL)
                begin
                    tx_state_d = udh_pkg::RDY_RELEASED;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_state_q <= udh_pkg::RDY_RELEASED;
            tx_state_q <= udh_pkg::RDY_RELEASED;
        end
        else if (cen)
        begin
            if (dma_mode_eff)
            begin
                rx_state_q <= rx_state_d;
                tx_state_q <= tx_state_d;
            end
            else
            begin
                rx_state_q <= udh_pkg::RDY_RELEASED;
                tx_state_q <= udh_pkg::RDY_RELEASED;
            end
        end
    end

    // Ready pins are registered so the DMA controller never sees a glitch
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_rdy_n_q <= 1'b1;
            tx_rdy_n_q <= 1'b1;
        end
        else if (cen)
        begin
            if (dma_mode_eff)
            begin
                rx_rdy_n_q <= (rx_state_d != udh_pkg::RDY_ASSERTED);
                tx_rdy_n_q <= (tx_state_d != udh_pkg::RDY_ASSERTED);
            end
            else
            begin
                rx_rdy_n_q <= level_empty(fifo_stat.rx_level);
                tx_rdy_n_q <= ~level_empty(fifo_stat.tx_level);
            end
        end
    end

    // Read data, valid in the cycle after the strobe only
    always_comb
    begin
        rdata_d = 1'b0;
        if (rd_en)
        begin
            rdata_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_q <= udh_pkg::RDATA_RST;
        end
        else if (cen)
        begin
            rdata_q <= udh_pkg::RDATA_RST;
            if (rdata_d)
            begin
                unique case (cpu_req.addr)
                    udh_pkg::MODEM_CTRL_OFS:
                    begin
                        rdata_q <= {{(udh_pkg::DATA_W - udh_pkg::MC_W){1'b0}}, modem_ctrl_q};
                    end
                    udh_pkg::FIFO_CTRL_OFS:
                    begin
                        rdata_q[udh_pkg::FC_FIFO_EN_BIT] <= fifo_en_q;
                        rdata_q[udh_pkg::FC_DMA_MODE_BIT] <= dma_mode_q;
                    end
                    udh_pkg::PIN_STATUS_OFS:
                    begin
                        rdata_q[udh_pkg::PS_RX_RDY_BIT] <= rx_rdy_n_q;
                        rdata_q[udh_pkg::PS_TX_RDY_BIT] <= tx_rdy_n_q;
                        rdata_q[udh_pkg::PS_FIFO_EN_BIT] <= fifo_en_q;
                        rdata_q[udh_pkg::PS_DMA_MODE_BIT] <= dma_mode_eff;
                        rdata_q[udh_pkg::PS_SIN_BIT] <= rx_line_q;
                        rdata_q[udh_pkg::PS_SERIAL_OUT_BIT] <= serial_out_q;
                    end
                    udh_pkg::RX_LEVEL_OFS:
                    begin
                        rdata_q[udh_pkg::LVL_W-1:0] <= fifo_stat.rx_level;
                    end
                    udh_pkg::TX_LEVEL_OFS:
                    begin
                        rdata_q[udh_pkg::LVL_W-1:0] <= fifo_stat.tx_level;
                    end
                    default:
                    begin
                        rdata_q <= udh_pkg::RDATA_RST;
                    end
                endcase
            end
        end
    end

    assign cpu_rdata = rdata_q;
    assign rx_serial_bit = rx_line_q;
    assign serial_out = serial_out_q;
    assign rts_n = rts_n_q;
    assign dtr_n = dtr_n_q;
    assign out1_n = out1_n_q;
    assign out2_n = out2_n_q;
    assign loopback = loop_q;
    assign fifo_enabled = fifo_en_q;
    assign rx_fifo_clear = rx_clr_q;
    assign tx_fifo_clear = tx_clr_q;
    assign rx_dma_ready_n = rx_rdy_n_q;
    assign tx_dma_ready_n = tx_rdy_n_q;

endmodule
`default_nettype wire

/* dv/udh_uart_dma_pins_props.sv */
`default_nettype none
module udh_uart_dma_pins_props #(
    parameter int unsigned FIFO_DEPTH = 16
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cen,
    input wire udh_pkg::udh_cpu_req_t cpu_req,
    input wire logic [udh_pkg::DATA_W-1:0] cpu_rdata,
    input wire udh_pkg::udh_fifo_stat_t fifo_stat,
    input wire logic serial_out,
    input wire logic rts_n,
    input wire logic loopback,
    input wire logic fifo_enabled,
    input wire logic rx_dma_ready_n,
    input wire logic tx_dma_ready_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic mc_wr;
    logic rd_any;
    assign mc_wr = cen && cpu_req.cs && (cpu_req.wr || !cpu_req.wr_n)
        && cpu_req.addr == udh_pkg::MODEM_CTRL_OFS;
    assign rd_any = cen && cpu_req.cs && (cpu_req.rd || !cpu_req.rd_n);

    property p_rts_follow;
        mc_wr && !cpu_req.wdata[udh_pkg::MC_LOOP_BIT]
            |-> ##2 rts_n == !$past(cpu_req.wdata[udh_pkg::MC_RTS_BIT], 2);
    endproperty
    a_rts_follow: assert property (p_rts_follow)
        else $error("rts pin does not follow modem control write");
    // Loop flag and forced pins come from the same register in the same cycle
    property p_rts_loop;
        loopback |-> rts_n && serial_out;
    endproperty
    a_rts_loop: assert property (p_rts_loop)
        else $error("pins not idle in loopback");
    property p_reset_idle;
        $rose(nrst) |-> rts_n && serial_out;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("pins not idle after reset");
    property p_rx_legacy;
        !fifo_enabled ##1 !fifo_enabled
            |-> rx_dma_ready_n == ($past(fifo_stat.rx_level) == '0);
    endproperty
    a_rx_legacy: assert property (p_rx_legacy)
        else $error("legacy receive ready wrong");
    property p_tx_legacy;
        !fifo_enabled ##1 !fifo_enabled
            |-> tx_dma_ready_n == ($past(fifo_stat.tx_level) != '0);
    endproperty
    a_tx_legacy: assert property (p_tx_legacy)
        else $error("legacy transmit ready wrong");
    property p_tx_full;
        fifo_stat.tx_level >= FIFO_DEPTH |=> tx_dma_ready_n;
    endproperty
    a_tx_full: assert property (p_tx_full)
        else $error("transmit ready not released when full");
    property p_tx_empty;
        fifo_stat.tx_level == '0 |=> !tx_dma_ready_n;
    endproperty
    a_tx_empty: assert property (p_tx_empty)
        else $error("transmit ready not asserted when empty");
    property p_rx_empty;
        fifo_stat.rx_level == '0 |=> rx_dma_ready_n;
    endproperty
    a_rx_empty: assert property (p_rx_empty)
        else $error("receive ready not released when empty");
    property p_rx_trig;
        (fifo_stat.rx_trigger || fifo_stat.rx_timeout) && fifo_stat.rx_level != '0
            |=> !rx_dma_ready_n;
    endproperty
    a_rx_trig: assert property (p_rx_trig)
        else $error("receive ready not asserted at trigger");
    property p_rd_idle;
        !rd_any |=> cpu_rdata == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read cycle");
    property p_rd_level;
        rd_any && cpu_req.addr == udh_pkg::RX_LEVEL_OFS
            |=> cpu_rdata == {3'h0, $past(fifo_stat.rx_level)};
    endproperty
    a_rd_level: assert property (p_rd_level)
        else $error("receive level read wrong");
endmodule
`default_nettype wire

/* dv/udh_dma_partner.sv */
`default_nettype none
module udh_dma_partner #(
    parameter int unsigned FIFO_DEPTH = 16,
    parameter int unsigned TRIG = 4
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic dma_on,
    input wire logic rx_push,
    input wire logic tx_pop,
    input wire logic rx_tmo,
    input wire logic rx_fifo_clear,
    input wire logic tx_fifo_clear,
    input wire logic rx_dma_ready_n,
    input wire logic tx_dma_ready_n,
    output udh_pkg::udh_fifo_stat_t fifo_stat
);
    logic [4:0] rx_q;
    logic [4:0] tx_q;
    // DMA moves one character per cycle while dma_on is high and the ready pin is low
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            rx_q <= 5'h00;
        else if (rx_fifo_clear)
            rx_q <= 5'h00;
        else if (rx_push && rx_q < FIFO_DEPTH)
            rx_q <= rx_q + 5'h01;
        else if (dma_on && !rx_dma_ready_n && rx_q != 5'h00)
            rx_q <= rx_q - 5'h01;
    end
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            tx_q <= 5'h00;
        else if (tx_fifo_clear)
            tx_q <= 5'h00;
        else if (tx_pop && tx_q != 5'h00)
            tx_q <= tx_q - 5'h01;
        else if (dma_on && !tx_dma_ready_n && tx_q < FIFO_DEPTH)
            tx_q <= tx_q + 5'h01;
    end
    // Levels, trigger flag and timeout flag in field order
    assign fifo_stat = {rx_q, tx_q, rx_q >= TRIG, rx_tmo};
endmodule
`default_nettype wire

/* dv/udh_uart_dma_pins_test.sv */
`default_nettype none
module udh_uart_dma_pins_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam udh_pkg::udh_cpu_req_t REQ_IDLE = '{1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 3'h0, 8'h00};
    logic core_clk, nrst, cen, tx_bit, dma_on, rx_push, tx_pop, rx_tmo;
    logic rx_bit, dtr_n, out1_n, out2_n;
    logic serial_out, rts_n, loopback, fifo_enabled, rx_clr, tx_clr, rx_rdy_n, tx_rdy_n;
    logic [7:0] cpu_rdata;
    logic [7:0] q;
    udh_pkg::udh_cpu_req_t cpu_req;
    udh_pkg::udh_fifo_stat_t fifo_stat;
    int errors = 0;
    int comparisons = 0;

    udh_uart_dma_pins #(.FIFO_DEPTH(16)) udh_uart_dma_pins_i (.core_clk(core_clk),
        .nrst(nrst), .cen(cen), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
        .fifo_stat(fifo_stat), .tx_serial_bit(tx_bit), .serial_in(1'h1), .rx_serial_bit(rx_bit),
        .serial_out(serial_out), .rts_n(rts_n), .dtr_n(dtr_n), .out1_n(out1_n), .out2_n(out2_n),
        .loopback(loopback), .fifo_enabled(fifo_enabled), .rx_fifo_clear(rx_clr),
        .tx_fifo_clear(tx_clr), .rx_dma_ready_n(rx_rdy_n), .tx_dma_ready_n(tx_rdy_n));
    udh_dma_partner #(.FIFO_DEPTH(16), .TRIG(4)) udh_dma_partner_i (.core_clk(core_clk),
        .nrst(nrst), .dma_on(dma_on), .rx_push(rx_push), .tx_pop(tx_pop), .rx_tmo(rx_tmo),
        .rx_fifo_clear(rx_clr), .tx_fifo_clear(tx_clr), .rx_dma_ready_n(rx_rdy_n),
        .tx_dma_ready_n(tx_rdy_n), .fifo_stat(fifo_stat));

    initial
    begin
        core_clk = 1'h0;
        forever #12.5 core_clk = !core_clk;
    end

    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Kind 0 write, 1 write low strobe, 2 read, 3 read low strobe
    task automatic bus(input logic [1:0] k, input logic [2:0] a, input logic [7:0] d,
        input logic cs);
        @(posedge core_clk);
        cpu_req <= '{cs, k == 2'h0, k != 2'h1, k == 2'h2, k != 2'h3, a, d};
        @(posedge core_clk);
        cpu_req <= REQ_IDLE;
        #1;
        q = cpu_rdata;
    endtask

    task automatic wait_rdy(input logic tx, input logic v);
        int i;
        for (i = 0; i < 64 && (tx ? tx_rdy_n : rx_rdy_n) !== v; i++)
            step(1);
        chk({7'h00, tx ? tx_rdy_n : rx_rdy_n}, {7'h00, v});
        if (i == 64)
            print_verdict();
    endtask

    task automatic pulse_rx(input int n);
        @(posedge core_clk);
        rx_push <= 1'h1;
        repeat (n) @(posedge core_clk);
        rx_push <= 1'h0;
        step(2);
    endtask

    task automatic t_rts();
        bus(2'h0, udh_pkg::MODEM_CTRL_OFS, 8'h0F, 1'h1);
        step(2);
        chk({4'h0, rts_n, dtr_n, out1_n, out2_n}, 8'h00);
        bus(2'h3, udh_pkg::MODEM_CTRL_OFS, 8'h00, 1'h1);
        chk(q, 8'h0F);
        bus(2'h1, udh_pkg::MODEM_CTRL_OFS, 8'h00, 1'h0);
        step(2);
        chk({7'h00, rts_n}, 8'h00);
        bus(2'h1, udh_pkg::MODEM_CTRL_OFS, 8'h00, 1'h1);
        step(2);
        chk({4'h0, rts_n, dtr_n, out1_n, out2_n}, 8'h0F);
        bus(2'h2, 3'h0, 8'h00, 1'h1);
        chk(q, 8'h00);
    endtask

    task automatic t_loop();
        chk({7'h00, serial_out}, 8'h00);
        bus(2'h0, udh_pkg::MODEM_CTRL_OFS, 8'h12, 1'h1);
        step(2);
        chk({2'h0, rts_n, dtr_n, out1_n, out2_n, serial_out, rx_bit}, 8'h3E);
        bus(2'h0, udh_pkg::MODEM_CTRL_OFS, 8'h02, 1'h1);
        step(2);
        chk({2'h0, rts_n, dtr_n, out1_n, out2_n, serial_out, rx_bit}, 8'h1D);
    endtask

    // A write while the clock enable is low must leave every register alone
    task automatic t_cen();
        @(posedge core_clk);
        cen <= 1'h0;
        bus(2'h0, udh_pkg::MODEM_CTRL_OFS, 8'h00, 1'h1);
        @(posedge core_clk);
        cen <= 1'h1;
        step(2);
        chk({7'h00, rts_n}, 8'h00);
        bus(2'h2, udh_pkg::MODEM_CTRL_OFS, 8'h00, 1'h1);
        chk(q, 8'h02);
    endtask

    task automatic t_legacy();
        bus(2'h0, udh_pkg::FIFO_CTRL_OFS, 8'h08, 1'h1);
        bus(2'h2, udh_pkg::FIFO_CTRL_OFS, 8'h00, 1'h1);
        chk(q, 8'h00);
        chk({7'h00, tx_rdy_n}, 8'h00);
        pulse_rx(1);
        wait_rdy(1'h0, 1'h0);
        dma_on <= 1'h1;
        wait_rdy(1'h0, 1'h1);
        wait_rdy(1'h1, 1'h1);
        dma_on <= 1'h0;
        chk({3'h0, fifo_stat.rx_level}, 8'h00);
        tx_pop <= 1'h1;
        step(20);
        tx_pop <= 1'h0;
        wait_rdy(1'h1, 1'h0);
    endtask

    task automatic t_mode1();
        bus(2'h0, udh_pkg::FIFO_CTRL_OFS, 8'h09, 1'h1);
        chk({6'h00, rx_clr, tx_clr}, 8'h03);
        bus(2'h2, udh_pkg::PIN_STATUS_OFS, 8'h00, 1'h1);
        chk({6'h00, q[3:2]}, 8'h03);
        dma_on <= 1'h1;
        wait_rdy(1'h1, 1'h1);
        chk({3'h0, fifo_stat.tx_level}, 8'h10);
        dma_on <= 1'h0;
        pulse_rx(2);
        chk({7'h00, rx_rdy_n}, 8'h01);
        rx_tmo <= 1'h1;
        step(1);
        rx_tmo <= 1'h0;
        wait_rdy(1'h0, 1'h0);
        step(3);
        chk({7'h00, rx_rdy_n}, 8'h00);
        pulse_rx(3);
        bus(2'h2, udh_pkg::RX_LEVEL_OFS, 8'h00, 1'h1);
        chk(q, 8'h05);
        dma_on <= 1'h1;
        wait_rdy(1'h0, 1'h1);
        chk({3'h0, fifo_stat.rx_level}, 8'h00);
        dma_on <= 1'h0;
    endtask

    task automatic t_fifo_mode0();
        bus(2'h0, udh_pkg::FIFO_CTRL_OFS, 8'h01, 1'h1);
        step(2);
        chk({7'h00, tx_rdy_n}, 8'h01);
        pulse_rx(1);
        wait_rdy(1'h0, 1'h0);
        dma_on <= 1'h1;
        wait_rdy(1'h0, 1'h1);
        dma_on <= 1'h0;
    endtask

    initial
    begin
        nrst = 1'h0;
        cen = 1'h1;
        tx_bit = 1'h0;
        dma_on = 1'h0;
        rx_push = 1'h0;
        tx_pop = 1'h0;
        rx_tmo = 1'h0;
        cpu_req = REQ_IDLE;
        step(1);
        chk({6'h00, rts_n, serial_out}, 8'h03);
        @(posedge core_clk);
        nrst <= 1'h1;
        step(1);
        t_rts();
        t_loop();
        t_cen();
        t_legacy();
        t_mode1();
        t_fifo_mode0();
        print_verdict();
    end
endmodule

bind udh_uart_dma_pins udh_uart_dma_pins_props #(.FIFO_DEPTH(FIFO_DEPTH)) props_i (
    .core_clk(core_clk), .nrst(nrst), .cen(cen), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .fifo_stat(fifo_stat), .serial_out(serial_out), .rts_n(rts_n), .loopback(loopback),
    .fifo_enabled(fifo_enabled), .rx_dma_ready_n(rx_dma_ready_n),
    .tx_dma_ready_n(tx_dma_ready_n));
`default_nettype wire
